//--- core/sspv_cfg.svh
// constants of the supply supervisor: field positions, reset values, timing
// assumes inclusion by bare name from the supervisor package and top module
`ifndef SSPV_CFG_SVH
`define SSPV_CFG_SVH
// clock rate in kHz (100 MHz always-on clock)
`define SSPV_CLK_KHZ 100000
// release delay in microseconds as printed (2.6 ms)
`define SSPV_RELEASE_DELAY_US 2600
// release delay in cycles, rounded up
`define SSPV_RELEASE_DELAY_CYC ((`SSPV_RELEASE_DELAY_US*`SSPV_CLK_KHZ+999)/1000)
// threshold select field width and reset value
`define SSPV_THR_W 3
`define SSPV_THR_RST 3'h0
// event line carrying the detector output
`define SSPV_EVT_LINE 16
// reset-source flag positions
`define SSPV_RSRC_W 3
`define SSPV_RSRC_PIN 0
`define SSPV_RSRC_SUPPLY 1
`define SSPV_RSRC_LOWPWR 2
`endif

//--- core/sspv_pkg.sv
// types of the supply supervisor
// assumes the constants header sits in the include path
`include "sspv_cfg.svh"
package sspv_pkg;
    // regulator operating modes, one-hot
    typedef enum logic [2:0] {
        SSPV_REG_RUN = 3'h1,
        SSPV_REG_STOP = 3'h2,
        SSPV_REG_STBY = 3'h4
    } sspv_reg_mode_t;
    // requested low-power mode from software
    typedef enum logic [1:0] {
        SSPV_REQ_RUN = 2'h0,
        SSPV_REQ_STOP = 2'h1,
        SSPV_REQ_STBY = 2'h2
    } sspv_req_t;
endpackage

//--- core/sspv_supervisor.sv
// supply supervisor: supply reset hold, voltage detector, regulator modes
// assumes comparator outputs are asynchronous levels and MCLK is always on
`include "sspv_cfg.svh"
module sspv_supervisor
    import sspv_pkg::*;
#(
    parameter int RELEASE_CYC = `SSPV_RELEASE_DELAY_CYC,
    parameter int THR_W = `SSPV_THR_W
) (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic SUPPLY_OK_CMP,
    input wire logic [7:0] DETECT_CMP,
    input wire logic SUPERVISOR_DISABLE_PIN,
    input wire logic EXTERNAL_RESET_PIN_N,
    input wire logic [THR_W-1:0] DETECT_THRESHOLD_SELECT,
    input wire logic DETECTOR_ENABLE_BIT,
    input wire logic EVT_RISE_EN,
    input wire logic EVT_FALL_EN,
    input wire logic EVT_IRQ_MASK,
    input wire logic EVT_PEND_CLR,
    input wire logic LOWPWR_RST_REQ,
    input wire logic RSRC_CLR,
    input wire sspv_pkg::sspv_req_t MODE_REQ,
    input wire logic WAKE,
    output logic SYSTEM_RESET,
    output logic [THR_W-1:0] DETECT_THRESHOLD_OUT,
    output logic DETECTOR_OUTPUT_FLAG,
    output logic EVT_PENDING,
    output logic EVT_IRQ,
    output logic REG_ENABLE,
    output logic REG_LOWPWR,
    output logic RETAIN_CONTENTS,
    output logic BATTERY_SWITCH,
    output logic [`SSPV_RSRC_W-1:0] RESET_SOURCE
);
    localparam int CW = $clog2(RELEASE_CYC + 1);

    logic supply_ok; // synchronised supply comparator
    logic pin_rst_n; // synchronised external reset pin
    logic sup_off; // synchronised supervisor disable strap
    logic [7:0] det_sync; // synchronised detector comparator taps
    logic [CW-1:0] rel_cnt; // release delay counter
    logic hold; // supply reset held
    logic det_prev; // previous detector level for edges
    logic det_valid; // previous level meaningful
    sspv_reg_mode_t mode; // regulator mode state
    logic lowpwr_hold; // one-cycle low-power reset latch

    // supply comparator through the three-stage chain
    sspv_sync3 #(.RST_VAL(1'b0)) u_sync_supply (
        .clk(MCLK),
        .rst(SYS_RST),
        .async_in(SUPPLY_OK_CMP),
        .level(supply_ok)
    );
    // external reset pin, idles high
    sspv_sync3 #(.RST_VAL(1'b1)) u_sync_pin (
        .clk(MCLK),
        .rst(SYS_RST),
        .async_in(EXTERNAL_RESET_PIN_N),
        .level(pin_rst_n)
    );
    // disable strap, same depth as the supply chain so both move together
    sspv_sync3 #(.RST_VAL(1'b0)) u_sync_off (
        .clk(MCLK),
        .rst(SYS_RST),
        .async_in(SUPERVISOR_DISABLE_PIN),
        .level(sup_off)
    );
    // one chain per detector threshold tap
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_det
            sspv_sync3 #(.RST_VAL(1'b1)) u_sync_det (
                .clk(MCLK),
                .rst(SYS_RST),
                .async_in(DETECT_CMP[gi]),
                .level(det_sync[gi])
            );
        end
    endgenerate

    // supervisor low when supply bad, unless disabled by the pin
    wire supply_low = ~supply_ok & ~sup_off;
    wire pin_low = ~pin_rst_n;
    // selected tap: high means supply above the chosen threshold
    wire det_sel = det_sync[DETECT_THRESHOLD_SELECT];
    wire det_level = DETECTOR_ENABLE_BIT & det_sel;
    wire det_rise = det_valid & det_level & ~det_prev;
    wire det_fall = det_valid & ~det_level & det_prev;
    wire det_event = DETECTOR_ENABLE_BIT &
        ((det_rise & EVT_RISE_EN) | (det_fall & EVT_FALL_EN));
    wire cnt_done = (rel_cnt == CW'(RELEASE_CYC - 1));
    wire lowpwr_evt = (mode == SSPV_REG_STBY) & WAKE;
    wire any_rst = hold | pin_low | lowpwr_hold;

    // release delay: restarted by every dip of the supply while the disable strap is clear
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            rel_cnt <= '0;
            hold <= 1'b1;
        end else if (supply_low) begin
            rel_cnt <= '0;
            hold <= 1'b1;
        end else if (hold) begin
            if (cnt_done) begin
                hold <= 1'b0;
            end else begin
                rel_cnt <= rel_cnt + CW'(1);
            end
        end
    end

    // system reset output and battery switchover
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            SYSTEM_RESET <= 1'b1;
            BATTERY_SWITCH <= 1'b1;
        end else begin
            SYSTEM_RESET <= any_rst;
            BATTERY_SWITCH <= hold;
        end
    end

    // detector flag and edge tracking
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            det_prev <= 1'b0;
            det_valid <= 1'b0;
            DETECTOR_OUTPUT_FLAG <= 1'b0;
            DETECT_THRESHOLD_OUT <= `SSPV_THR_RST;
        end else begin
            det_prev <= det_level;
            det_valid <= DETECTOR_ENABLE_BIT;
            DETECTOR_OUTPUT_FLAG <= det_level;
            DETECT_THRESHOLD_OUT <= DETECT_THRESHOLD_SELECT;
        end
    end

    // pending bit of the event line; set wins over clear
    always_ff @(posedge MCLK) begin
        if (SYS_RST | any_rst) begin
            EVT_PENDING <= 1'b0;
            EVT_IRQ <= 1'b0;
        end else begin
            if (det_event) begin
                EVT_PENDING <= 1'b1;
            end else if (EVT_PEND_CLR) begin
                EVT_PENDING <= 1'b0;
            end
            EVT_IRQ <= (EVT_PENDING | det_event) & EVT_IRQ_MASK;
        end
    end

    // regulator mode state
    always_ff @(posedge MCLK) begin
        if (SYS_RST | any_rst) begin
            mode <= SSPV_REG_RUN;
        end else begin
            unique case (mode)
                SSPV_REG_RUN: begin
                    if (MODE_REQ == SSPV_REQ_STOP) begin
                        mode <= SSPV_REG_STOP;
                    end else if (MODE_REQ == SSPV_REQ_STBY) begin
                        mode <= SSPV_REG_STBY;
                    end
                end
                SSPV_REG_STOP: begin
                    if (WAKE) begin
                        mode <= SSPV_REG_RUN;
                    end
                end
                SSPV_REG_STBY: begin
                    mode <= SSPV_REG_STBY; // left only by reset
                end
                default: begin
                    mode <= SSPV_REG_RUN;
                end
            endcase
        end
    end

    // regulator outputs from the mode
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            REG_ENABLE <= 1'b1;
            REG_LOWPWR <= 1'b0;
            RETAIN_CONTENTS <= 1'b1;
            lowpwr_hold <= 1'b0;
        end else begin
            REG_ENABLE <= (mode != SSPV_REG_STBY);
            REG_LOWPWR <= (mode == SSPV_REG_STOP);
            RETAIN_CONTENTS <= (mode != SSPV_REG_STBY);
            lowpwr_hold <= lowpwr_evt | LOWPWR_RST_REQ;
        end
    end

    // reset-source flags rewritten with the active sources during any reset, cleared by SYS_RST or software
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            RESET_SOURCE <= '0;
        end else if (hold | pin_low | lowpwr_hold) begin
            RESET_SOURCE[`SSPV_RSRC_SUPPLY] <= hold;
            RESET_SOURCE[`SSPV_RSRC_PIN] <= pin_low;
            RESET_SOURCE[`SSPV_RSRC_LOWPWR] <= lowpwr_hold;
        end else if (RSRC_CLR) begin
            RESET_SOURCE <= '0;
        end
    end

    // assertions
    property p_hold_low;
        @(posedge MCLK) disable iff (SYS_RST)
        supply_low |=> hold;
    endproperty
    a_hold_low: assert property (p_hold_low) else $error("no hold");

    property p_rst_out;
        @(posedge MCLK) disable iff (SYS_RST)
        hold |=> SYSTEM_RESET;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("rst drop");

    property p_release;
        @(posedge MCLK) disable iff (SYS_RST)
        $fell(hold) |-> rel_cnt == CW'(RELEASE_CYC - 1);
    endproperty
    a_release: assert property (p_release) else $error("early");

    property p_restart;
        @(posedge MCLK) disable iff (SYS_RST)
        supply_low |=> rel_cnt == '0;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart");

    property p_thr;
        @(posedge MCLK) disable iff (SYS_RST)
        ##1 DETECT_THRESHOLD_OUT == $past(DETECT_THRESHOLD_SELECT);
    endproperty
    a_thr: assert property (p_thr) else $error("thr");

    property p_off;
        @(posedge MCLK) disable iff (SYS_RST)
        !DETECTOR_ENABLE_BIT |=> !$rose(EVT_PENDING);
    endproperty
    a_off: assert property (p_off) else $error("evt off");

    property p_flag;
        @(posedge MCLK) disable iff (SYS_RST)
        DETECTOR_ENABLE_BIT |=> DETECTOR_OUTPUT_FLAG == $past(det_sel);
    endproperty
    a_flag: assert property (p_flag) else $error("flag");

    property p_irq;
        @(posedge MCLK) disable iff (SYS_RST)
        EVT_IRQ |-> $past(EVT_IRQ_MASK);
    endproperty
    a_irq: assert property (p_irq) else $error("irq mask");

    property p_edge;
        @(posedge MCLK) disable iff (SYS_RST)
        (det_rise & EVT_RISE_EN & !any_rst) |=> EVT_PENDING;
    endproperty
    a_edge: assert property (p_edge) else $error("edge");

    sequence s_stop;
        mode == SSPV_REG_STOP;
    endsequence
    property p_stop;
        @(posedge MCLK) disable iff (SYS_RST)
        s_stop |=> REG_LOWPWR && RETAIN_CONTENTS;
    endproperty
    a_stop: assert property (p_stop) else $error("stop");

    property p_stby;
        @(posedge MCLK) disable iff (SYS_RST)
        mode == SSPV_REG_STBY |=> !REG_ENABLE && !RETAIN_CONTENTS;
    endproperty
    a_stby: assert property (p_stby) else $error("stby");

    property p_src;
        @(posedge MCLK) disable iff (SYS_RST)
        hold |=> RESET_SOURCE[`SSPV_RSRC_SUPPLY];
    endproperty
    a_src: assert property (p_src) else $error("src");

    property p_lp;
        @(posedge MCLK) disable iff (SYS_RST)
        lowpwr_hold |=> SYSTEM_RESET && RESET_SOURCE[`SSPV_RSRC_LOWPWR];
    endproperty
    a_lp: assert property (p_lp) else $error("lp src");

    property p_bat;
        @(posedge MCLK) disable iff (SYS_RST)
        hold |=> BATTERY_SWITCH;
    endproperty
    a_bat: assert property (p_bat) else $error("bat");
endmodule

//--- core/sspv_sync3.sv
// three-stage synchroniser with agreement of the last two stages
// assumes an asynchronous level input and the single always-on clock
module sspv_sync3 #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic async_in,
    output logic level
);
    logic s1; // first stage, read only by s2
    logic s2;
    logic s3;
    // shift chain; level moves once s2 and s3 agree
    always_ff @(posedge clk) begin
        if (rst) begin
            s1 <= RST_VAL;
            s2 <= RST_VAL;
            s3 <= RST_VAL;
            level <= RST_VAL;
        end else begin
            s1 <= async_in;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                level <= s3;
            end
        end
    end
endmodule

//--- dv/sspv_ana_model.sv
// behavioural model of the analog comparators and board reset circuit
// assumes a supply level from the bench: 0 = below reset threshold
module sspv_ana_model (
    input wire logic [3:0] lvl,
    input wire logic dis_pin,
    output logic supply_ok,
    output logic [7:0] detect_cmp,
    output logic ext_rst_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // any level above zero clears the reset comparator
    assign supply_ok = (lvl != 4'h0);
    // tap n trips when the level reaches n plus two
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            detect_cmp[n] = (lvl >= 4'(n + 2));
        end
    end
    // board pulls the reset pin low while supervisor is off and supply low
    assign ext_rst_n = !(dis_pin && lvl == 4'h0);
endmodule

//--- dv/tb.sv
// self-checking bench of the supply supervisor
// assumes the supervisor design files and the comparator model compile first
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
    bad_count++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sspv_pkg::*;
    localparam int RC = 20; // shortened release delay
    int bad_count = 0; // mismatches
    int total_checks = 0; // comparisons
    int n; // cycles counted to release
    logic MCLK = 0, SYS_RST = 1, dis = 0, den = 0, rise = 0, fall = 0;
    logic mask = 0, pclr = 0, rclr = 0, wake = 0, lreq = 0;
    logic [3:0] lvl = 4'h0; // supply level seen by the comparators
    logic [2:0] thr = 3'h0; // threshold select
    sspv_req_t mreq = SSPV_REQ_RUN; // requested mode
    logic sok, ext_n, srst, flag, pend, irq, ren, rlp, ret, bat;
    logic [7:0] dcmp;
    logic [2:0] thr_o, rsrc;
    // comparators and board circuit
    sspv_ana_model i_sspv_ana_model (.lvl(lvl), .dis_pin(dis),
        .supply_ok(sok), .detect_cmp(dcmp), .ext_rst_n(ext_n));
    // device under test
    sspv_supervisor #(.RELEASE_CYC(RC)) i_sspv_supervisor (.MCLK(MCLK),
        .SYS_RST(SYS_RST), .SUPPLY_OK_CMP(sok), .DETECT_CMP(dcmp),
        .SUPERVISOR_DISABLE_PIN(dis), .EXTERNAL_RESET_PIN_N(ext_n),
        .DETECT_THRESHOLD_SELECT(thr), .DETECTOR_ENABLE_BIT(den),
        .EVT_RISE_EN(rise), .EVT_FALL_EN(fall), .EVT_IRQ_MASK(mask),
        .EVT_PEND_CLR(pclr), .LOWPWR_RST_REQ(lreq), .RSRC_CLR(rclr),
        .MODE_REQ(mreq), .WAKE(wake), .SYSTEM_RESET(srst),
        .DETECT_THRESHOLD_OUT(thr_o), .DETECTOR_OUTPUT_FLAG(flag),
        .EVT_PENDING(pend), .EVT_IRQ(irq), .REG_ENABLE(ren),
        .REG_LOWPWR(rlp), .RETAIN_CONTENTS(ret), .BATTERY_SWITCH(bat),
        .RESET_SOURCE(rsrc));
    // free-running clock, 10 ns period
    initial forever #5 MCLK = ~MCLK;
    // step c falling edges, where inputs change
    task cyc(input int c);
        repeat (c) @(negedge MCLK);
    endtask
    // count cycles until reset drops, bounded
    task wait_rel();
        n = 0;
        while (srst !== 1'b0 && n < 400) begin
            cyc(1);
            n++;
        end
    endtask
    // one pulse on a control input
    task pulse_wake();
        wake = 1;
        cyc(1);
        wake = 0;
    endtask
    // arm edge selects, clear pending, then move the level from a to b
    task edge_chk(input logic r, input logic f, input logic m,
                  input logic [3:0] a, input logic [3:0] b, input logic e);
        rise = r;
        fall = f;
        mask = m;
        lvl = a;
        cyc(8);
        pclr = 1;
        cyc(1);
        pclr = 0;
        cyc(1);
        `CHK("pend_clr", 1'b0, pend)
        lvl = b;
        cyc(8);
        `CHK("pend", e, pend)
        `CHK("irq", e & m, irq)
    endtask
    // closing verdict
    task report_and_stop();
        $display("checks %0d bad %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // watchdog well beyond the expected run length
    initial begin
        #50us;
        bad_count++;
        report_and_stop();
    end
    // main sequence
    initial begin
        cyc(10);
        SYS_RST = 0;
        cyc(50);
        `CHK("hold_low", 1'b1, srst)
        `CHK("bat_low", 1'b1, bat)
        // dip during the release delay restarts the count
        lvl = 4'h9;
        cyc(10);
        lvl = 4'h0;
        cyc(8);
        `CHK("dip", 1'b1, srst)
        lvl = 4'h9;
        wait_rel();
        `CHK("delay", 1'b1, n >= RC && n <= RC + 8)
        `CHK("bat_up", 1'b0, bat)
        `CHK("reg_en", 1'b1, ren)
        `CHK("reg_lp", 1'b0, rlp)
        `CHK("src_sup", 1'b1, rsrc[1])
        // disabled detector: no flag, no event, both edges armed
        rise = 1;
        fall = 1;
        mask = 1;
        lvl = 4'h3;
        cyc(8);
        pclr = 1;
        cyc(1);
        pclr = 0;
        lvl = 4'h1;
        cyc(8);
        `CHK("dis_flag", 1'b0, flag)
        `CHK("dis_pend", 1'b0, pend)
        `CHK("dis_irq", 1'b0, irq)
        den = 1;
        // every threshold tap, just above and just below
        for (int s = 0; s < 8; s++) begin
            thr = 3'(s);
            lvl = 4'(s + 2);
            cyc(8);
            `CHK("thr_o", 3'(s), thr_o)
            `CHK("above", 1'b1, flag)
            lvl = 4'(s + 1);
            cyc(8);
            `CHK("below", 1'b0, flag)
        end
        thr = 3'h0;
        edge_chk(1, 0, 1, 4'h1, 4'h3, 1);
        edge_chk(1, 0, 1, 4'h3, 4'h1, 0);
        edge_chk(0, 1, 1, 4'h3, 4'h1, 1);
        edge_chk(0, 1, 1, 4'h1, 4'h3, 0);
        edge_chk(1, 1, 0, 4'h1, 4'h3, 1);
        // stop then wake back to run
        mreq = SSPV_REQ_STOP;
        cyc(4);
        `CHK("stop_lp", 1'b1, rlp)
        `CHK("stop_ret", 1'b1, ret)
        `CHK("stop_en", 1'b1, ren)
        mreq = SSPV_REQ_RUN;
        pulse_wake();
        cyc(4);
        `CHK("run_lp", 1'b0, rlp)
        // standby loses contents, wake resets the chip
        mreq = SSPV_REQ_STBY;
        cyc(4);
        `CHK("stby_en", 1'b0, ren)
        `CHK("stby_ret", 1'b0, ret)
        mreq = SSPV_REQ_RUN;
        pulse_wake();
        cyc(1);
        `CHK("wake_rst", 1'b1, srst)
        wait_rel();
        `CHK("src_lp", 1'b1, rsrc[2])
        `CHK("pend_rst", 1'b0, pend)
        `CHK("reg_en2", 1'b1, ren)
        // supervisor off: board drives the reset pin
        rclr = 1;
        cyc(1);
        rclr = 0;
        cyc(1);
        `CHK("src_clr", 3'h0, rsrc)
        dis = 1;
        lvl = 4'h0;
        cyc(8);
        `CHK("pin_rst", 1'b1, srst)
        `CHK("src_pin", 1'b1, rsrc[0])
        `CHK("bat_dis", 1'b0, bat)
        lvl = 4'h9;
        wait_rel();
        `CHK("pin_rel", 1'b0, srst)
        // low-power management request resets and is recorded
        lreq = 1;
        cyc(1);
        lreq = 0;
        cyc(1);
        `CHK("lp_req", 1'b1, srst)
        `CHK("src_req", 3'h4, rsrc)
        report_and_stop();
    end
endmodule
